/* hdl/resonant_protection_pkg.sv */
// Purpose: Shared constants and types for the resonant protection sequencer
// Assumes: 10 MHz system clock
// Notes: Times are given in their own unit; cycle counts are derived
package resonant_protection_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int START_PULSE_NS = 500;
    // Start pulse width in clocks, least time rounded up
    localparam int START_PULSE_CYC =
        (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_PULSE_COUNT = 4;
    localparam int OVERLOAD_TRIP = 8192;
    localparam int RESTART_ATTEMPTS = 32;
    localparam int PEAK_CUTOFF_MV = 400;
    localparam int OVL_WIDTH = 14;
    localparam int ATTEMPT_WIDTH = 6;
    localparam int PULSE_WIDTH = 4;
    // Start pulses also follow release of reset
    localparam logic [2:0] START_COUNT_RESET = 3'h4;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DORMANT = 2'b01,
        ST_BURST_IDLE = 2'b10
    } seq_state_t;

    // Comparator results, one bit each
    typedef struct packed {
        logic over_overload;
        logic peak_cutoff;
        logic at_min_freq;
        logic at_max_freq;
        logic light_load;
        logic more_power;
        logic ramp_done;
    } comp_bits_t;

    // Drive pin controls
    typedef struct packed {
        logic clamp_a;
        logic clamp_b;
        logic start_a;
        logic start_b;
    } drive_t;

endpackage : resonant_protection_pkg

/* hdl/resonant_protection_sequencer.sv */
// Purpose: Overload counting, dormant restart, peak cutoff and burst idle
// Assumes: Comparator outputs are asynchronous analog results
// Notes: One half-cycle ends on each synchronised ramp_done rising edge

// Behaviour
// - Overload counter counts up above overload level, down below it.
// - Net overload count of 8192 enters dormant and stops converter.
// - After shutdown, 32 dummy restart attempts pass, then start pulses.
// - Restart trips again if overload persists, else it keeps running.
// - Peak current above 400 mV ends on-time at once.
// - Peak cutoff acts in every cycle independently, never latched.
// - Half-cycle ends when ramp reaches control voltage; next starts.
// - Maximum frequency or light load enters burst idle.
// - Demand for more power leaves burst idle and starts.
// - Running at minimum frequency increments the overload counter.
// - Overload counter decrements toward zero, never below zero.
// - Dormant state clamps both drive outputs.
// - Dormant state closes supply to timing pin switch.
// - Each start gives 500 ns pulses on the first four on-times.
module resonant_protection_sequencer #(
    parameter int OVERLOAD_TRIP = resonant_protection_pkg::OVERLOAD_TRIP,
    parameter int RESTART_ATTEMPTS = resonant_protection_pkg::RESTART_ATTEMPTS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire resonant_protection_pkg::comp_bits_t comp_in,
    output resonant_protection_pkg::drive_t drive_out,
    output logic half_cycle_end,
    output logic on_time_end,
    output logic supply_switch_closed,
    output logic dormant,
    output logic burst_idle
);

    localparam int OW = resonant_protection_pkg::OVL_WIDTH;
    localparam int AW = resonant_protection_pkg::ATTEMPT_WIDTH;
    localparam int PW = resonant_protection_pkg::PULSE_WIDTH;
    localparam logic [OW:0] TRIP_VAL = (OW+1)'(OVERLOAD_TRIP);
    localparam logic [AW-1:0] ATTEMPT_VAL = AW'(RESTART_ATTEMPTS);
    localparam logic [PW-1:0] PULSE_VAL =
        PW'(resonant_protection_pkg::START_PULSE_CYC);

    resonant_protection_pkg::comp_bits_t sync1_reg;
    resonant_protection_pkg::comp_bits_t sync2_reg;
    logic ramp_prev_reg;
    logic step;
    resonant_protection_pkg::seq_state_t state_reg;
    resonant_protection_pkg::seq_state_t state_next;
    logic [OW:0] ovl_reg;
    logic [OW:0] ovl_next;
    logic [AW-1:0] attempt_reg;
    logic [2:0] start_cnt_reg;
    logic [PW-1:0] pulse_reg;
    logic trip;
    logic start_req;

    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // Two-stage synchroniser for all comparator inputs
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= comp_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ramp_prev_reg <= 1'b0;
        end else begin
            ramp_prev_reg <= sync2_reg.ramp_done;
        end
    end

    // Counter and state read the inputs only on this step
    assign step = sync2_reg.ramp_done & ~ramp_prev_reg;
    assign half_cycle_end = step;
    // Peak cutoff acts straight from the synchronised comparator
    assign on_time_end = step | sync2_reg.peak_cutoff;

    assign trip = (ovl_next >= TRIP_VAL);

    always_comb begin
        ovl_next = ovl_reg;
        if (state_reg == resonant_protection_pkg::ST_RUN && step) begin
            if (sync2_reg.over_overload || sync2_reg.at_min_freq) begin
                ovl_next = ovl_reg + (OW+1)'(1);
            end else if (ovl_reg != '0) begin
                ovl_next = ovl_reg - (OW+1)'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovl_reg <= '0;
        end else if (state_next == resonant_protection_pkg::ST_DORMANT &&
                     state_reg != resonant_protection_pkg::ST_DORMANT) begin
            ovl_reg <= '0;
        end else begin
            ovl_reg <= ovl_next;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            resonant_protection_pkg::ST_RUN: begin
                if (step && trip) begin
                    state_next = resonant_protection_pkg::ST_DORMANT;
                end else if (step &&
                    (sync2_reg.at_max_freq || sync2_reg.light_load)) begin
                    state_next = resonant_protection_pkg::ST_BURST_IDLE;
                end
            end
            resonant_protection_pkg::ST_DORMANT: begin
                if (step && attempt_reg == ATTEMPT_VAL - AW'(1)) begin
                    state_next = resonant_protection_pkg::ST_RUN;
                end
            end
            resonant_protection_pkg::ST_BURST_IDLE: begin
                if (step && sync2_reg.more_power) begin
                    state_next = resonant_protection_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = resonant_protection_pkg::ST_DORMANT;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= resonant_protection_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Dummy restart attempts, one per half-cycle while dormant
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            attempt_reg <= '0;
        end else if (state_reg != resonant_protection_pkg::ST_DORMANT) begin
            attempt_reg <= '0;
        end else if (step) begin
            attempt_reg <= attempt_reg + AW'(1);
        end
    end

    assign start_req = (state_next == resonant_protection_pkg::ST_RUN) &&
                       (state_reg != resonant_protection_pkg::ST_RUN);

    // Four start pulses, each at the start of an on-time
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_cnt_reg <= resonant_protection_pkg::START_COUNT_RESET;
            pulse_reg <= '0;
        end else if (start_req) begin
            start_cnt_reg <= 3'(resonant_protection_pkg::START_PULSE_COUNT);
            pulse_reg <= '0;
        end else if (state_reg != resonant_protection_pkg::ST_RUN) begin
            start_cnt_reg <= '0;
            pulse_reg <= '0;
        end else if (step && start_cnt_reg != 3'h0) begin
            start_cnt_reg <= start_cnt_reg - 3'h1;
            pulse_reg <= PULSE_VAL;
        end else if (pulse_reg != '0) begin
            pulse_reg <= pulse_reg - PW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_out <= '0;
            supply_switch_closed <= 1'b0;
            dormant <= 1'b0;
            burst_idle <= 1'b0;
        end else begin
            drive_out.clamp_a <=
                state_next != resonant_protection_pkg::ST_RUN;
            drive_out.clamp_b <=
                state_next != resonant_protection_pkg::ST_RUN;
            drive_out.start_a <= state_reg == resonant_protection_pkg::ST_RUN
                && step && start_cnt_reg != 3'h0;
            drive_out.start_b <= state_reg == resonant_protection_pkg::ST_RUN
                && step && start_cnt_reg != 3'h0;
            if (pulse_reg > PW'(1)) begin
                drive_out.start_a <= 1'b1;
                drive_out.start_b <= 1'b1;
            end
            supply_switch_closed <=
                state_next == resonant_protection_pkg::ST_DORMANT;
            dormant <= state_next == resonant_protection_pkg::ST_DORMANT;
            burst_idle <= state_next == resonant_protection_pkg::ST_BURST_IDLE;
        end
    end

    a_dormant_clamps: assert property (
        dormant |-> drive_out.clamp_a && drive_out.clamp_b && supply_switch_closed)
        else $error("dormant without clamps or switch");

    a_switch_dormant: assert property (
        supply_switch_closed ==
        (state_reg == resonant_protection_pkg::ST_DORMANT))
        else $error("supply switch disagrees with dormant state");

    a_trip_sleep: assert property (
        state_reg == resonant_protection_pkg::ST_RUN && step && trip
        |=> state_reg == resonant_protection_pkg::ST_DORMANT && ovl_reg == '0)
        else $error("overload trip did not enter dormant");

    a_ovl_floor: assert property (
        ovl_reg == '0 && !(sync2_reg.over_overload || sync2_reg.at_min_freq)
        |=> ovl_reg == '0)
        else $error("overload counter went below zero");

    a_ovl_up: assert property (
        state_reg == resonant_protection_pkg::ST_RUN && step && !trip &&
        (sync2_reg.over_overload || sync2_reg.at_min_freq)
        |=> ovl_reg == $past(ovl_reg) + (OW+1)'(1))
        else $error("overload counter did not count up");

    a_ovl_down: assert property (
        state_reg == resonant_protection_pkg::ST_RUN && step &&
        !(sync2_reg.over_overload || sync2_reg.at_min_freq) && ovl_reg != '0
        |=> ovl_reg == $past(ovl_reg) - (OW+1)'(1))
        else $error("overload counter did not count down");

    a_peak_cut: assert property (
        comp_in.peak_cutoff |-> ##2 on_time_end)
        else $error("peak cutoff did not end on-time");

    a_burst_exit: assert property (
        state_reg == resonant_protection_pkg::ST_BURST_IDLE && step &&
        sync2_reg.more_power
        |=> state_reg == resonant_protection_pkg::ST_RUN &&
        start_cnt_reg == 3'(resonant_protection_pkg::START_PULSE_COUNT))
        else $error("burst idle exit failed");

    a_burst_entry: assert property (
        state_reg == resonant_protection_pkg::ST_RUN && step && !trip &&
        (sync2_reg.light_load || sync2_reg.at_max_freq) |=> burst_idle)
        else $error("burst condition did not enter burst idle");

    sequence s_pulse_start;
        state_reg == resonant_protection_pkg::ST_RUN && step &&
        start_cnt_reg != 3'h0;
    endsequence

    a_pulse_width: assert property (
        s_pulse_start |=> drive_out.start_a [*5] ##1 !drive_out.start_a)
        else $error("start pulse width wrong");

endmodule : resonant_protection_sequencer

/* verification/power_stage_model.sv */
// Purpose: Half-bridge power stage seen through the two drive pins
// Assumes: Start pulses are start_a and start_b levels from the sequencer
// Notes: Counts start pulses, keeps the last width, flags bad drive
module power_stage_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire resonant_protection_pkg::drive_t drive_out,
    output int pulses,
    output int last_width,
    output logic fault
);
    timeunit 1ns;
    timeprecision 1ns;
    int width;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulses <= 0;
            width <= 0;
            last_width <= 0;
        end else if (drive_out.start_a) begin
            width <= width + 1;
            if (width == 0) begin
                pulses <= pulses + 1;
            end
        end else begin
            if (width != 0) begin
                last_width <= width;
            end
            width <= 0;
        end
    end

    // Both pins pulse together and never while clamped
    assign fault = (drive_out.start_a != drive_out.start_b) ||
        (drive_out.start_a &&
        (drive_out.clamp_a || drive_out.clamp_b));
endmodule : power_stage_model

/* verification/testbench.sv */
// Purpose: Directed test of overload, restart, burst and peak cutoff
// Assumes: Shortened trip count 16 and restart count 4
// Notes: One step is ramp high 3 clocks then low 5 clocks
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TRIP = 16;
    localparam int ATTEMPTS = 4;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    resonant_protection_pkg::comp_bits_t comp_in = '0;
    resonant_protection_pkg::drive_t drive_out;
    logic half_cycle_end, on_time_end, supply_switch_closed;
    logic dormant, burst_idle, fault;
    int pulses, last_width, p0;
    int mismatches = 0, total_checks = 0, cycles = 0, steps = 0, ends = 0;

    always #50 sys_clk = ~sys_clk;

    resonant_protection_sequencer #(
        .OVERLOAD_TRIP(TRIP),
        .RESTART_ATTEMPTS(ATTEMPTS)
    ) dut (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .comp_in(comp_in),
        .drive_out(drive_out),
        .half_cycle_end(half_cycle_end),
        .on_time_end(on_time_end),
        .supply_switch_closed(supply_switch_closed),
        .dormant(dormant),
        .burst_idle(burst_idle)
    );

    power_stage_model model (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .drive_out(drive_out),
        .pulses(pulses),
        .last_width(last_width),
        .fault(fault)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic step(input int n);
        repeat (n) begin
            comp_in.ramp_done = 1'b1;
            repeat (3) @(negedge sys_clk);
            comp_in.ramp_done = 1'b0;
            repeat (5) @(negedge sys_clk);
            steps++;
        end
    endtask : step

    // Dormant, burst idle, both clamps, supply switch
    function automatic logic [31:0] st();
        return 32'({dormant, burst_idle, drive_out.clamp_a,
            drive_out.clamp_b, supply_switch_closed});
    endfunction : st

    always @(negedge sys_clk) begin
        if (half_cycle_end === 1'b1) begin
            ends++;
        end
        if (reset_n && fault !== 1'b0) begin
            chk(32'(fault), 32'h0);
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        chk(st(), 32'h0);
        step(3);
        comp_in.over_overload = 1'b1;
        step(4);
        chk(32'(pulses), 32'h4);
        comp_in.over_overload = 1'b0;
        step(2);
        comp_in.over_overload = 1'b1;
        step(TRIP - 3);
        chk(st(), 32'h0);
        step(1);
        chk(st(), 32'h17);
        p0 = pulses;
        step(ATTEMPTS - 1);
        chk(st(), 32'h17);
        step(1);
        chk(st(), 32'h0);
        step(TRIP - 1);
        chk(32'(pulses - p0), 32'h4);
        chk(32'(last_width),
            32'(resonant_protection_pkg::START_PULSE_CYC));
        chk(st(), 32'h0);
        step(1);
        chk(st(), 32'h17);
        comp_in.over_overload = 1'b0;
        comp_in.at_min_freq = 1'b1;
        step(ATTEMPTS + TRIP - 1);
        chk(st(), 32'h0);
        step(1);
        chk(st(), 32'h17);
        comp_in.at_min_freq = 1'b0;
        step(ATTEMPTS + TRIP + 2);
        chk(st(), 32'h0);
        for (int i = 0; i < 2; i++) begin
            comp_in.light_load = (i == 0);
            comp_in.at_max_freq = (i == 1);
            step(1);
            chk(st(), 32'hE);
            comp_in.light_load = 1'b0;
            comp_in.at_max_freq = 1'b0;
            comp_in.more_power = 1'b1;
            p0 = pulses;
            step(1);
            chk(st(), 32'h0);
            comp_in.more_power = 1'b0;
            step(5);
            chk(32'(pulses - p0), 32'h4);
        end
        for (int i = 0; i < 2; i++) begin
            comp_in.peak_cutoff = 1'b1;
            repeat (3) @(negedge sys_clk);
            chk(32'(on_time_end), 32'h1);
            comp_in.peak_cutoff = 1'b0;
            repeat (3) @(negedge sys_clk);
            chk(32'(on_time_end), 32'h0);
        end
        chk(32'(ends), 32'(steps));
        end_of_test();
    end
endmodule : testbench
